// file: hw/dcc_top.sv
/*
 * dual-array capture/compare unit: four reloadable time bases, 32 capture/
 * compare channels, pin logic and an apb register slave with no wait state.
 * assumes port pins and count inputs are already synchronous to clk and
 * that gpt_ovf is a one-cycle overflow pulse from gpt2_core_timer.
 */
`timescale 1ns/1ps
module dcc_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic gpt_ovf,
	input wire logic [1:0] ext_cnt,
	input wire logic [dcc_pkg::NCH-1:0] cc_in,
	output logic [dcc_pkg::NCH-1:0] cc_out,
	output logic [dcc_pkg::NCH-1:0] cc_oe_n,
	output logic [dcc_pkg::NCH-1:0] cc_irq
);
	import dcc_pkg::*;

	// divide-by-2^k tick from the free prescaler
	function automatic logic ptick(input logic [7:0] c, input logic [2:0] k);
		logic [7:0] mk;
		mk = 8'((9'h001 << k) - 9'h001);
		return (c & mk) == mk;
	endfunction : ptick

	logic [15:0] cc_q [NCH];
	logic [6:0] ctl_q [NCH];
	logic pin_q [NCH];
	logic oen_q [NCH];
	logic seen_q [NCH];
	logic done_q [NCH];
	logic irq_q [NCH];
	logic [15:0] tmr_q [NTM];
	logic [15:0] rel_q [NTM];
	logic [5:0] tctl_q [NTM];
	logic [NCH-1:0] pin_p_q;
	logic [1:0] ext_p_q;
	logic [7:0] pre_q;
	logic [2:0] slot_q;
	logic stg_q;
	logic [31:0] prdata_q;
	logic err_q;
	logic [NCH-1:0] cap_v;
	logic [NCH-1:0] mat_v;
	logic [NCH-1:0] dtog_v;
	logic [NTM-1:0] tick_v;
	logic [NTM-1:0] ovf_v;
	logic [NTM-1:0] tchg_v;

	// address decode shared by reads and writes
	wire [4:0] reg_blk = paddr[11:7];
	wire [4:0] idx = paddr[6:2];
	wire [2:0] sub = paddr[6:4];
	wire [1:0] ti = paddr[3:2];
	wire in_val = reg_blk == OFS_VAL[11:7];
	wire in_ctl = reg_blk == OFS_CTL[11:7];
	wire in_tmr = reg_blk == OFS_TMR[11:7];
	wire s_tmr = in_tmr & (sub == OFS_TMR[6:4]);
	wire s_rel = in_tmr & (sub == OFS_REL[6:4]);
	wire s_tctl = in_tmr & (sub == OFS_TCTL[6:4]);
	wire s_glb = in_tmr & (sub == OFS_GLB[6:4]) & (ti == OFS_GLB[3:2]);
	wire mapped = in_val | in_ctl | s_tmr | s_rel | s_tctl | s_glb;
	wire setup = psel & ~penable;
	wire wen = psel & penable & pwrite & mapped;
	wire [1:0] ext_rise = ext_cnt & ~ext_p_q;

	// read data selection, taken into a flop in the setup cycle
	wire [31:0] rd_val = {16'h0000, cc_q[idx]};
	wire [31:0] rd_ctl = {23'h000000, pin_q[idx], 1'b0, ctl_q[idx]};
	wire [31:0] rd_tm = s_tmr ? {16'h0000, tmr_q[ti]} :
		s_rel ? {16'h0000, rel_q[ti]} :
		s_tctl ? {26'h0000000, tctl_q[ti]} :
		s_glb ? {31'h00000000, stg_q} : 32'h00000000;
	wire [31:0] rdata_d = in_val ? rd_val : in_ctl ? rd_ctl : rd_tm;

	// zero wait states: data is ready because it was sampled at setup
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = err_q & psel & penable;

	// bus flops, prescaler, stagger slot and pin history
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata_q <= 32'h00000000;
			err_q <= 1'b0;
			pre_q <= 8'h00;
			slot_q <= 3'h0;
			stg_q <= 1'b0;
			pin_p_q <= '0;
			ext_p_q <= 2'h0;
		end else begin
			if (setup) begin
				prdata_q <= rdata_d;
				err_q <= ~mapped;
			end
			if (wen & s_glb)
				stg_q <= pwdata[GF_STG];
			pre_q <= pre_q + 8'h01;
			slot_q <= slot_q + 3'h1;
			pin_p_q <= cc_in;
			ext_p_q <= ext_cnt;
		end
	end

	// time bases
	for (genvar t = 0; t < NTM; t++) begin : g_tm
		localparam int A = t / 2;
		localparam bit EXT = (t % 2) == 0;
		wire run = tctl_q[t][TF_RUN];
		wire [1:0] src = tctl_q[t][TF_SRC+1:TF_SRC];
		wire [2:0] pre = tctl_q[t][TF_PRE+2:TF_PRE];
		// staggered: advance once per 8-cycle round so every slot sees each value
		wire stg_ok = ~stg_q | (slot_q == STG_LAST);
		wire hit = ((src == S_PRE) & ptick(pre_q, pre)) |
			((src == S_GPT) & gpt_ovf) |
			((src == S_EXT) & EXT & ext_rise[A]);
		wire twr = wen & s_tmr & (ti == 2'(t));
		assign tick_v[t] = run & stg_ok & hit;
		assign ovf_v[t] = tick_v[t] & (tmr_q[t] == TMR_TOP);
		assign tchg_v[t] = tick_v[t] | twr;

		always_ff @(posedge clk) begin
			if (!nrst) begin
				tmr_q[t] <= RST_TMR;
				rel_q[t] <= RST_TMR;
				tctl_q[t] <= RST_TCTL;
			end else begin
				if (twr)
					tmr_q[t] <= pwdata[15:0];
				else if (ovf_v[t])
					tmr_q[t] <= rel_q[t];
				else if (tick_v[t])
					tmr_q[t] <= tmr_q[t] + 16'h0001;
				if (wen & s_rel & (ti == 2'(t)))
					rel_q[t] <= pwdata[15:0];
				if (wen & s_tctl & (ti == 2'(t)))
					tctl_q[t] <= pwdata[5:0];
			end
		end
	end

	// capture/compare channels
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		localparam int A = i / 16;
		localparam int L = i % 16;
		localparam bit HASP = (A == 0) || (L < PINNED2);
		localparam bit LOWER = L < 8;
		localparam int P = LOWER ? i + 8 : i;
		wire [1:0] tb = {1'(A), ctl_q[i][CF_TSEL]};
		wire [2:0] m = ctl_q[i][2:0];
		wire en = ctl_q[i][CF_EN];
		wire once = m[1]; // modes 2 and 3 act once per period
		wire rise = HASP & cc_in[i] & ~pin_p_q[i];
		wire fall = HASP & ~cc_in[i] & pin_p_q[i];
		wire slot_ok = ~stg_q | (slot_q == 3'(i));
		wire part_tog = LOWER & dtog_v[P];
		wire part_cfg = LOWER & ctl_q[P][CF_DBL] & ctl_q[P][2];
		wire own_tog = mat_v[i] & (m == M_CMP1) & ~dtog_v[i];
		wire set = mat_v[i] & (m == M_CMP3);
		wire clr = ovf_v[tb] & (m == M_CMP3);
		wire vwr = wen & in_val & (idx == 5'(i));
		wire cwr = wen & in_ctl & (idx == 5'(i));
		// capture bits 0/1 pick rising/falling edge, both set means both
		assign cap_v[i] = en & ~m[2] & ((rise & m[0]) | (fall & m[1]));
		// seen_q blocks repeat matches while a slow timer holds one value
		assign mat_v[i] = en & m[2] & slot_ok & ~seen_q[i] &
			~(once & done_q[i]) & (tmr_q[tb] == cc_q[i]);
		// an upper register in double mode steers its lower partner's pin
		assign dtog_v[i] = mat_v[i] & ctl_q[i][CF_DBL] & !LOWER;
		assign cc_out[i] = HASP & pin_q[i];
		assign cc_oe_n[i] = oen_q[i];
		assign cc_irq[i] = irq_q[i];

		always_ff @(posedge clk) begin
			if (!nrst) begin
				cc_q[i] <= RST_VAL;
				ctl_q[i] <= RST_CTL;
				pin_q[i] <= 1'b0;
				oen_q[i] <= 1'b1;
				seen_q[i] <= 1'b0;
				done_q[i] <= 1'b0;
				irq_q[i] <= 1'b0;
			end else begin
				// a capture in the cycle of a software write keeps the capture
				if (cap_v[i])
					cc_q[i] <= tmr_q[tb];
				else if (vwr)
					cc_q[i] <= pwdata[15:0];
				if (cwr)
					ctl_q[i] <= pwdata[6:0];
				else if (mat_v[i] & ctl_q[i][CF_SGL])
					ctl_q[i][CF_EN] <= 1'b0;
				if (own_tog | part_tog)
					pin_q[i] <= ~pin_q[i];
				else if (set)
					pin_q[i] <= 1'b1;
				else if (clr)
					pin_q[i] <= 1'b0;
				oen_q[i] <= ~(HASP & ((m[2] & m[0]) | part_cfg));
				seen_q[i] <= ~tchg_v[tb] & (seen_q[i] | mat_v[i]);
				done_q[i] <= ~ovf_v[tb] & (done_q[i] | (mat_v[i] & once));
				irq_q[i] <= cap_v[i] | mat_v[i];
			end
		end
	end

	// checks on channel 0, its partner, timer 0 and the stagger slot of channel 1
	wire [1:0] tb0 = {1'b0, ctl_q[0][CF_TSEL]};
	wire [2:0] m0 = ctl_q[0][2:0];
	wire wr0 = wen & (in_val | in_ctl) & (idx == 5'h00);
	wire twr0 = wen & s_tmr & (ti == 2'h0);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_reload;
		ovf_v[0] && !twr0 |=> tmr_q[0] == $past(rel_q[0]);
	endproperty
	a_reload: assert property (p_reload) else $error("timer did not reload");

	property p_count;
		tick_v[0] && !ovf_v[0] && !twr0 |=> tmr_q[0] == $past(tmr_q[0]) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("timer did not count");

	property p_capture;
		cap_v[0] && !wr0 |=> cc_q[0] == $past(tmr_q[tb0]) && cc_irq[0];
	endproperty
	a_capture: assert property (p_capture) else $error("capture lost");

	property p_mode0;
		mat_v[0] && m0 == M_CMP0 && !dtog_v[8] |=> $stable(cc_out[0]) && cc_irq[0];
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 moved pin");

	property p_mode1;
		mat_v[0] && m0 == M_CMP1 |=> cc_out[0] != $past(cc_out[0]);
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 1 did not toggle");

	property p_mode2;
		mat_v[0] && m0 == M_CMP2 && !ovf_v[tb0] && !wr0 ##1 !ovf_v[tb0] |-> !mat_v[0];
	endproperty
	a_mode2: assert property (p_mode2) else $error("mode 2 matched twice");

	property p_mode3;
		mat_v[0] && m0 == M_CMP3 && !dtog_v[8] |=> cc_out[0];
	endproperty
	a_mode3: assert property (p_mode3) else $error("mode 3 pin not set");

	property p_mode3_clr;
		ovf_v[tb0] && m0 == M_CMP3 && !mat_v[0] && !dtog_v[8] |=> !cc_out[0];
	endproperty
	a_mode3_clr: assert property (p_mode3_clr) else $error("mode 3 pin not cleared");

	property p_double;
		dtog_v[8] && !mat_v[0] |=> cc_out[0] != $past(cc_out[0]);
	endproperty
	a_double: assert property (p_double) else $error("shared pin did not toggle");

	property p_single;
		mat_v[0] && ctl_q[0][CF_SGL] && !wr0 |=> !ctl_q[0][CF_EN] ##1 !mat_v[0];
	endproperty
	a_single: assert property (p_single) else $error("single event repeated");

	property p_stagger;
		stg_q && mat_v[1] |-> slot_q == 3'h1 ##1 cc_irq[1];
	endproperty
	a_stagger: assert property (p_stagger) else $error("match off its slot");

	c_capture: cover property (cap_v[0] ##1 cc_irq[0]);
	c_toggle: cover property (mat_v[0] && m0 == M_CMP1);
	c_reload: cover property (ovf_v[0]);
	c_stagger: cover property (stg_q && mat_v[1]);
endmodule : dcc_top

// file: hw/dcc_pkg.sv
/*
 * constants shared by the dual-array capture/compare block: register map,
 * field positions, reset values and mode codes.
 * assumes a 32-bit apb bus with a 12-bit byte address and one clock.
 */
package dcc_pkg;
	localparam int NCH = 32;
	localparam int NTM = 4;
	localparam int PINNED2 = 12;
	// byte offsets
	localparam logic [11:0] OFS_VAL = 12'h000;
	localparam logic [11:0] OFS_CTL = 12'h080;
	localparam logic [11:0] OFS_TMR = 12'h100;
	localparam logic [11:0] OFS_REL = 12'h110;
	localparam logic [11:0] OFS_TCTL = 12'h120;
	localparam logic [11:0] OFS_GLB = 12'h130;
	// channel control fields
	localparam int CF_TSEL = 3;
	localparam int CF_SGL = 4;
	localparam int CF_DBL = 5;
	localparam int CF_EN = 6;
	// timer control fields
	localparam int TF_RUN = 0;
	localparam int TF_SRC = 1;
	localparam int TF_PRE = 3;
	localparam int GF_STG = 0;
	// channel modes
	localparam logic [2:0] M_OFF = 3'h0;
	localparam logic [2:0] M_CAPR = 3'h1;
	localparam logic [2:0] M_CAPF = 3'h2;
	localparam logic [2:0] M_CAPB = 3'h3;
	localparam logic [2:0] M_CMP0 = 3'h4;
	localparam logic [2:0] M_CMP1 = 3'h5;
	localparam logic [2:0] M_CMP2 = 3'h6;
	localparam logic [2:0] M_CMP3 = 3'h7;
	// timer clock sources
	localparam logic [1:0] S_PRE = 2'h0;
	localparam logic [1:0] S_GPT = 2'h1;
	localparam logic [1:0] S_EXT = 2'h2;
	// reset values and stagger timing
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam logic [6:0] RST_CTL = 7'h00;
	localparam logic [5:0] RST_TCTL = 6'h00;
	localparam logic [15:0] RST_TMR = 16'h0000;
	localparam logic [15:0] TMR_TOP = 16'hffff;
	localparam logic [2:0] STG_LAST = 3'h7;
endpackage : dcc_pkg

// file: testbench/dcc_pin_model.sv
/* pin side model: outside drivers of capture pins and count inputs.
 * assumes its tasks are called by the bench right after a rising edge. */
`timescale 1ns/1ps
module dcc_pin_model (
	input wire logic clk,
	input wire logic [31:0] cc_out,
	input wire logic [31:0] cc_oe_n,
	output logic [31:0] cc_in,
	output logic [1:0] ext_cnt,
	output logic gpt_ovf
);
	logic [31:0] lvl = 32'h0;
	// a driven pin reads back its own level, a released one the outside driver
	assign cc_in = (cc_out & ~cc_oe_n) | (lvl & cc_oe_n);
	initial begin
		ext_cnt = 2'h0;
		gpt_ovf = 1'h0;
	end
	task set_pin(input int i, input logic v);
		@(posedge clk);
		lvl[i] <= v;
	endtask : set_pin
	// one high cycle then one low, so each pulse is a fresh edge
	task pulse(input int src);
		@(posedge clk);
		if (src == 2) gpt_ovf <= 1'h1;
		else ext_cnt[src] <= 1'h1;
		@(posedge clk);
		gpt_ovf <= 1'h0;
		ext_cnt <= 2'h0;
	endtask : pulse
endmodule : dcc_pin_model

// file: testbench/testbench.sv
/* self-checking bench for dcc_top: apb master, pin model, scenario tasks.
 * assumes one 20 mhz clock; waits on pready and never counts on its timing. */
`timescale 1ns/1ps
module testbench;
	import dcc_pkg::*;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, cc_in, cc_out, cc_oe_n, cc_irq, rd;
	logic pready, pslverr, gpt_ovf, err;
	logic [1:0] ext_cnt;
	int n_errors = 0;
	int checked = 0;
	int irqs[32];
	int togs[32];
	// 50 ns period
	always #25 clk = ~clk;
	dcc_top i_dcc_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gpt_ovf(gpt_ovf), .ext_cnt(ext_cnt),
		.cc_in(cc_in), .cc_out(cc_out), .cc_oe_n(cc_oe_n), .cc_irq(cc_irq));
	dcc_pin_model i_dcc_pin_model (.clk(clk), .cc_out(cc_out), .cc_oe_n(cc_oe_n),
		.cc_in(cc_in), .ext_cnt(ext_cnt), .gpt_ovf(gpt_ovf));
	task complete_run;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// request held until pready is sampled high; data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task clr;
		irqs = '{default: 0};
		togs = '{default: 0};
	endtask : clr
	// counts irq pulses and pin changes over n cycles, sampled at the falling
	// edge so registered outputs are settled and never raced at their launch edge
	task watch(input int n);
		logic [31:0] prv;
		prv = cc_out;
		repeat (n) begin
			@(negedge clk);
			for (int c = 0; c < NCH; c++) begin
				irqs[c] += int'(cc_irq[c] === 1'h1);
				togs[c] += int'(cc_out[c] !== prv[c]);
			end
			prv = cc_out;
		end
	endtask : watch
	task t_reset;
		apb(1'h0, OFS_CTL, 32'h0);
		chk("ctl0", rd, {25'h0, RST_CTL});
		apb(1'h0, OFS_TMR, 32'h0);
		chk("tmr0", rd, {16'h0, RST_TMR});
		apb(1'h0, 12'h200, 32'h0);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("oe after reset", cc_oe_n, 32'hffffffff);
	endtask : t_reset
	// external count feeds t2, gpt overflow feeds t3
	task t_count;
		apb(1'h1, OFS_TCTL + 12'h8, {26'h0, 3'h0, S_EXT, 1'h1});
		apb(1'h1, OFS_TCTL + 12'hc, {26'h0, 3'h0, S_GPT, 1'h1});
		repeat (5) i_dcc_pin_model.pulse(1);
		repeat (3) i_dcc_pin_model.pulse(2);
		apb(1'h0, OFS_TMR + 12'h8, 32'h0);
		chk("ext count", rd, 32'h5);
		apb(1'h0, OFS_TMR + 12'hc, 32'h0);
		chk("gpt count", rd, 32'h3);
	endtask : t_count
	// channel 2 on stopped t1, every edge choice
	task t_capture;
		for (int m = 1; m < 4; m++) begin
			apb(1'h1, OFS_TMR + 12'h4, 32'h1000 + m);
			apb(1'h1, OFS_CTL + 12'h8, {25'h0, 4'h9, m[2:0]});
			clr;
			i_dcc_pin_model.set_pin(2, 1'h1);
			watch(4);
			i_dcc_pin_model.set_pin(2, 1'h0);
			watch(4);
			chk("cap irq", irqs[2], (m == 3) ? 2 : 1);
			apb(1'h0, OFS_VAL + 12'h8, 32'h0);
			chk("cap val", rd, 32'h1000 + m);
		end
	endtask : t_capture
	// t0 reloads fff0, so one period is 16 cycles and 64 cycles hold four
	task t_compare;
		apb(1'h1, OFS_REL, 32'hfff0);
		apb(1'h1, OFS_TMR, 32'hfff0);
		apb(1'h1, OFS_TCTL, 32'h1);
		apb(1'h1, OFS_VAL, 32'hfff8);
		apb(1'h1, OFS_CTL, 32'h47);
		apb(1'h1, OFS_VAL + 12'h4, 32'hfff8);
		apb(1'h1, OFS_CTL + 12'h4, 32'h45);
		apb(1'h1, OFS_VAL + 12'h24, 32'hfff4);
		apb(1'h1, OFS_CTL + 12'h24, 32'h65);
		apb(1'h1, OFS_VAL + 12'hc, 32'hfffa);
		apb(1'h1, OFS_CTL + 12'hc, 32'h46);
		apb(1'h1, OFS_VAL + 12'h14, 32'hfffc);
		apb(1'h1, OFS_CTL + 12'h14, 32'h44);
		apb(1'h1, OFS_VAL + 12'h70, 32'hfff2);
		apb(1'h1, OFS_CTL + 12'h70, 32'h45);
		apb(1'h1, OFS_VAL + 12'h10, 32'hfffa);
		apb(1'h1, OFS_CTL + 12'h10, 32'h54);
		clr;
		watch(64);
		chk("mode3 pin edges", togs[0], 32'h8);
		chk("mode3 irq", irqs[0], 32'h4);
		chk("mode1 irq", irqs[1], 32'h4);
		chk("mode1 oe", cc_oe_n[1], 32'h0);
		chk("double pin edges", togs[1], 32'h8);
		chk("double irq", irqs[9], 32'h4);
		chk("mode2 irq", irqs[3], 32'h4);
		chk("mode0 irq", irqs[5], 32'h4);
		chk("single irq", irqs[4], 32'h1);
		chk("no pin oe", cc_oe_n[31:28], 32'hf);
		chk("no pin out", cc_out[31:28], 32'h0);
	endtask : t_compare
	// staggered: t0 ticks once per 8 cycles, so a 16-value period spans 128 cycles
	task t_stagger;
		apb(1'h1, OFS_GLB, 32'h1);
		clr;
		watch(128);
		chk("stagger mode0 irq", irqs[5], 32'h1);
		chk("stagger mode1 irq", irqs[1], 32'h1);
		apb(1'h1, OFS_GLB, 32'h0);
	endtask : t_stagger
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		t_reset;
		t_count;
		t_capture;
		t_compare;
		t_stagger;
		complete_run;
	end
	// watchdog, well beyond the few hundred cycles the tests take
	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		complete_run;
	end
endmodule : testbench
